// file: cvp_pkg.sv
// Constants shared by the component video path and its output FIFO.
// Assumes one pixel clock that drives the whole path.
package cvp_pkg;
    // ==========================================
    // Widths and depths
    localparam int DW = 9;
    localparam int FIFO_W = 17;
    localparam int FIFO_D = 16;
    localparam int PIPE_LEN = 6;
    // ==========================================
    // Register map, byte addresses
    localparam logic [4:0] ADDR_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_CONTRAST = 5'h04;
    localparam logic [4:0] ADDR_BRIGHTNESS = 5'h08;
    localparam logic [4:0] ADDR_SATURATION = 5'h0C;
    localparam logic [4:0] ADDR_STATUS = 5'h10;
    localparam int CTRL_PEAK_BIT = 0;
    localparam int CTRL_BYPASS_BIT = 1;
    localparam logic [7:0] DEF_CONTRAST = 8'h44;
    localparam logic [7:0] DEF_BRIGHTNESS = 8'h80;
    localparam logic [7:0] DEF_SATURATION = 8'h40;
    // ==========================================
    // Matrix coefficients, scaled by 2**MAT_SHIFT
    localparam int MAT_SHIFT = 10;
    localparam logic [10:0] K_YR = 11'h132;
    localparam logic [10:0] K_YG = 11'h259;
    localparam logic [10:0] K_YB = 11'h075;
    localparam logic [10:0] K_CB = 11'h24F;
    localparam logic [10:0] K_CR = 11'h2EB;
    localparam logic signed [13:0] CHROMA_OFS = 14'sh0100;
    localparam logic signed [13:0] S9_MAX = 14'sh01FF;
    localparam logic [8:0] SAMPLE_MIN = 9'h000;
    localparam logic [8:0] SAMPLE_MAX = 9'h1FF;
    localparam int PEAK_SHIFT = 4;
    // ==========================================
    // Level adjust
    localparam logic signed [19:0] CON_DIV = 20'sh00044;
    localparam logic signed [19:0] SAT_DIV = 20'sh00040;
    localparam logic signed [9:0] MID8 = 10'sh080;
    localparam logic signed [19:0] MID8_W = 20'sh00080;
    localparam logic [7:0] LIM_MIN = 8'h01;
    localparam logic [7:0] LIM_MAX = 8'hFE;
    localparam logic signed [19:0] LIM_MIN_W = 20'sh00001;
    localparam logic signed [19:0] LIM_MAX_W = 20'sh000FE;
endpackage

// file: component_video_path.sv
// Component video path: matrix, downformatter, luma peaking, level adjust,
// output FIFO and Avalon-MM register slave.
// Assumes source samples come from logic on the same clock.
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/100ps

// ==========================================
// Output FIFO
module stream_fifo
    import cvp_pkg::*;
#(
    parameter int WIDTH = FIFO_W,
    parameter int DEPTH = FIFO_D
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Fill side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // Drain side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    // Fill level
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic push;
    logic pop;

    assign inReady = level != (AW+1)'(DEPTH);
    assign outValid = level != '0;
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign outData = mem[rdPtr];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
        end else begin
            wrPtr <= wrPtr + AW'(push);
            rdPtr <= rdPtr + AW'(pop);
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// What this block does
// - Luma is 0.299 red plus 0.587 green plus 0.114 blue.
// - Cb is 0.5772 times blue minus luma, Cr 0.7296 times red minus luma.
// - The matrix takes and gives 9-bit words at unity gain.
// - A bypass for component inputs has the same latency as the matrix.
// - Both colour differences are low-pass filtered before decimation.
// - Cr is delayed one clock ahead of the multiplexer to align slots.
// - The phase is low on a slot's first clock, where Cb is selected.
// - The chroma output is registered, so it runs opposite the select.
// - A small luma high-pass on the delay taps gives 2 dB at 6.75 MHz.
// - The luma filter has unity DC gain and clips to 0..511.
// - One software bit turns the whole luma filter on or off.
// - Luma out is int(contrast/68 times (Y minus 128)) plus brightness.
// - Chroma out is int(saturation/64 times (C minus 128)) plus 128.
// - Every level adjust output is limited to 1..254.
// - Contrast, brightness, saturation reset to 44h, 80h and 40h.
module component_video_path
    import cvp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Avalon-MM slave
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Source samples (red/green/blue, or Cr/Y/Cb in bypass)
    input wire logic [DW-1:0] inRed,
    input wire logic [DW-1:0] inGreen,
    input wire logic [DW-1:0] inBlue,
    input wire logic inValid,
    output logic inReady,
    // Output stream
    output logic outValid,
    input wire logic outReady,
    output logic [7:0] outLuma,
    output logic [7:0] outChroma,
    output logic outCrPhase
);
    function automatic logic [DW-1:0] clip9(input logic signed [13:0] v);
        if (v < 0) begin
            clip9 = SAMPLE_MIN;
        end else if (v > S9_MAX) begin
            clip9 = SAMPLE_MAX;
        end else begin
            clip9 = v[DW-1:0];
        end
    endfunction

    function automatic logic [7:0] limit8(input logic signed [19:0] v);
        if (v < LIM_MIN_W) begin
            limit8 = LIM_MIN;
        end else if (v > LIM_MAX_W) begin
            limit8 = LIM_MAX;
        end else begin
            limit8 = v[7:0];
        end
    endfunction

    // ==========================================
    // Register slave
    logic busAck;
    logic luma_peaking_enable;
    logic bypass;
    logic [7:0] component_contrast;
    logic [7:0] component_brightness;
    logic [7:0] component_saturation;
    logic [$clog2(FIFO_D):0] fifoLevel;
    logic fifoInReady;
    logic doWrite;

    assign waitrequest = (read || write) && !busAck;
    assign doWrite = write && busAck && byteenable[0];

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            busAck <= 1'b0;
        end else begin
            busAck <= (read || write) && !busAck;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            luma_peaking_enable <= 1'b0;
            bypass <= 1'b0;
            component_contrast <= DEF_CONTRAST;
            component_brightness <= DEF_BRIGHTNESS;
            component_saturation <= DEF_SATURATION;
        end else if (doWrite) begin
            unique case (address)
                ADDR_CONTROL: begin
                    luma_peaking_enable <= writedata[CTRL_PEAK_BIT];
                    bypass <= writedata[CTRL_BYPASS_BIT];
                end
                ADDR_CONTRAST: component_contrast <= writedata[7:0];
                ADDR_BRIGHTNESS: component_brightness <= writedata[7:0];
                ADDR_SATURATION: component_saturation <= writedata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            readdata <= '0;
        end else if (read && !busAck) begin
            unique case (address)
                ADDR_CONTROL: begin
                    readdata <= 32'({bypass, luma_peaking_enable});
                end
                ADDR_CONTRAST: readdata <= 32'(component_contrast);
                ADDR_BRIGHTNESS: readdata <= 32'(component_brightness);
                ADDR_SATURATION: readdata <= 32'(component_saturation);
                ADDR_STATUS: readdata <= 32'({!fifoInReady, fifoLevel});
                default: readdata <= '0;
            endcase
        end
    end

    // ==========================================
    // Pipeline advance: stalls whole path when the FIFO is full
    logic step;
    logic [PIPE_LEN-1:0] vPipe;

    assign inReady = fifoInReady;
    assign step = inValid && fifoInReady;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            vPipe <= '0;
        end else if (step) begin
            vPipe <= {vPipe[PIPE_LEN-2:0], 1'b1};
        end
    end

    // ==========================================
    // Matrix with bypass, two stages either way
    logic [19:0] ySum;
    logic [DW-1:0] y1, r1, b1, y2, cb2, cr2;
    logic signed [10:0] cbDiff, crDiff;
    logic signed [21:0] cbProd, crProd;

    assign ySum = 20'(K_YR) * 20'(inRed) + 20'(K_YG) * 20'(inGreen)
        + 20'(K_YB) * 20'(inBlue);
    assign cbDiff = $signed({2'b00, b1}) - $signed({2'b00, y1});
    assign crDiff = $signed({2'b00, r1}) - $signed({2'b00, y1});
    assign cbProd = cbDiff * $signed({1'b0, K_CB});
    assign crProd = crDiff * $signed({1'b0, K_CR});

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            y1 <= '0;
            r1 <= '0;
            b1 <= '0;
            y2 <= '0;
            cb2 <= '0;
            cr2 <= '0;
        end else if (step) begin
            y1 <= bypass ? inGreen : ySum[MAT_SHIFT +: DW];
            r1 <= inRed;
            b1 <= inBlue;
            y2 <= y1;
            cb2 <= bypass ? b1
                : clip9(14'(cbProd >>> MAT_SHIFT) + CHROMA_OFS);
            cr2 <= bypass ? r1
                : clip9(14'(crProd >>> MAT_SHIFT) + CHROMA_OFS);
        end
    end

    // ==========================================
    // Downformatter: chroma low-pass [1 2 1]/4, channel 0 Cb, 1 Cr
    logic [DW-1:0] cFilt [2];
    logic [DW-1:0] crDel;
    logic muxSel;
    logic [DW-1:0] chromaMux;
    logic outPhase;

    for (genvar ch = 0; ch < 2; ch++) begin : g_chroma
        logic [DW-1:0] tap0, tap1, tap2;
        logic [10:0] cSum;
        assign cSum = 11'(tap0) + 11'({tap1, 1'b0}) + 11'(tap2);
        assign cFilt[ch] = cSum[10:2];
        always_ff @(posedge clock or posedge reset) begin
            if (reset) begin
                tap0 <= '0;
                tap1 <= '0;
                tap2 <= '0;
            end else if (step) begin
                tap0 <= (ch == 0) ? cb2 : cr2;
                tap1 <= tap0;
                tap2 <= tap1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            crDel <= '0;
            muxSel <= 1'b0;
            chromaMux <= '0;
            outPhase <= 1'b1;
        end else if (step) begin
            crDel <= cFilt[1];
            muxSel <= !muxSel;
            chromaMux <= muxSel ? crDel : cFilt[0];
            outPhase <= muxSel;
        end
    end

    // ==========================================
    // Luma peaking on the delay taps
    logic [DW-1:0] yA, yB, yC, yPk;
    logic signed [11:0] yHigh;
    logic signed [13:0] yBoost;

    assign yHigh = $signed({2'b00, yB, 1'b0}) - $signed({3'b000, yA})
        - $signed({3'b000, yC});
    assign yBoost = $signed({5'h00, yB}) + 14'(yHigh >>> PEAK_SHIFT);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            yA <= '0;
            yB <= '0;
            yC <= '0;
            yPk <= '0;
        end else if (step) begin
            yA <= y2;
            yB <= yA;
            yC <= yB;
            yPk <= luma_peaking_enable ? clip9(yBoost) : yB;
        end
    end

    // ==========================================
    // Level adjust
    logic signed [9:0] yCent, cCent;
    logic signed [19:0] yProd, cProd, yLev, cLev;
    logic [7:0] lumaAdj, chromaAdj;
    logic phaseAdj;

    assign yCent = $signed({2'b00, yPk[DW-1:1]}) - MID8;
    assign cCent = $signed({2'b00, chromaMux[DW-1:1]}) - MID8;
    assign yProd = 20'(yCent) * 20'($signed({1'b0, component_contrast}));
    assign cProd = 20'(cCent) * 20'($signed({1'b0, component_saturation}));
    assign yLev = yProd / CON_DIV
        + $signed({12'h000, component_brightness});
    assign cLev = cProd / SAT_DIV + MID8_W;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lumaAdj <= LIM_MIN;
            chromaAdj <= LIM_MIN;
            phaseAdj <= 1'b0;
        end else if (step) begin
            lumaAdj <= limit8(yLev);
            chromaAdj <= limit8(cLev);
            phaseAdj <= outPhase;
        end
    end

    // ==========================================
    // Output FIFO
    logic [FIFO_W-1:0] fifoOut;

    stream_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .clock(clock),
        .reset(reset),
        .inData({phaseAdj, chromaAdj, lumaAdj}),
        .inValid(step && vPipe[PIPE_LEN-1]),
        .inReady(fifoInReady),
        .outData(fifoOut),
        .outValid(outValid),
        .outReady(outReady),
        .level(fifoLevel)
    );

    assign outLuma = fifoOut[7:0];
    assign outChroma = fifoOut[15:8];
    assign outCrPhase = fifoOut[16];

    // ==========================================
    // Checks
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    sequence stepBypass;
        step && bypass;
    endsequence

    bypassLatency_a: assert property (
        stepBypass ##1 stepBypass |=> y2 == $past(inGreen, 2))
        else $error("bypass luma latency wrong");
    crDelay_a: assert property (
        step ##1 step && muxSel |=> chromaMux == $past(cFilt[1], 2))
        else $error("Cr not delayed one step");
    cbSelect_a: assert property (
        step && !muxSel |=> chromaMux == $past(cFilt[0]) && !outPhase)
        else $error("Cb not selected at slot start");
    phaseOpposite_a: assert property (
        outPhase != muxSel)
        else $error("output phase not opposite to select");
    peakOff_a: assert property (
        step && !luma_peaking_enable |=> yPk == $past(yB))
        else $error("luma filter active while off");
    lumaLimit_a: assert property (
        lumaAdj >= LIM_MIN && lumaAdj <= LIM_MAX)
        else $error("luma outside 1..254");
    chromaLimit_a: assert property (
        chromaAdj >= LIM_MIN && chromaAdj <= LIM_MAX)
        else $error("chroma outside 1..254");
    busAnswer_a: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus answer late");
    fifoFull_a: assert property (
        fifoLevel == ($clog2(FIFO_D)+1)'(FIFO_D) |-> !inReady)
        else $error("full FIFO still ready");
    peakDcGain_a: assert property (
        step && luma_peaking_enable && yA == yB && yB == yC
        |=> yPk == $past(yB))
        else $error("luma filter DC gain not one");
    peakBoost_a: assert property (
        step && luma_peaking_enable && {1'b0, yB} >= {1'b0, yA} + 10'h008
        && {1'b0, yB} >= {1'b0, yC} + 10'h008
        |=> yPk > $past(yB) || $past(yB) == SAMPLE_MAX)
        else $error("luma filter gives no high boost");
endmodule

// file: video_sink.sv
// Sink model standing after the output FIFO: takes words with random stalls.
// Assumes the path's clock and reset; holdOff forces a full stall.
`timescale 1ns/100ps
module video_sink (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Stream handshake
    output logic outReady,
    // Stall control
    input wire logic holdOff
);
    int seed = 10;

    // ==========================================
    // Ready with roughly one stall in four
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            outReady <= 1'b0;
        end else begin
            outReady <= !holdOff && ($random(seed) % 4 != 0);
        end
    end
endmodule

// file: tb_component_video_path.sv
// Self-checking bench for the component video path.
// Assumes cvp_pkg, the design and the sink model in video_sink.sv.
`timescale 1ns/100ps
module tb_component_video_path;
    import cvp_pkg::*;
    // ==========================================
    // Signals
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [DW-1:0] inRed = 9'h000;
    logic [DW-1:0] inGreen = 9'h000;
    logic [DW-1:0] inBlue = 9'h000;
    logic inValid = 1'b0;
    logic inReady, outValid, outReady, outCrPhase;
    logic [7:0] outLuma, outChroma;
    logic holdOff = 1'b0;
    logic byp = 1'b0;
    logic [24:0] expQ[$];
    logic [24:0] e;
    logic [31:0] q;
    logic [4:0] addrs[6] = '{ADDR_CONTROL, ADDR_CONTRAST, ADDR_BRIGHTNESS,
        ADDR_SATURATION, ADDR_STATUS, 5'h14};
    logic [31:0] rstv[6] = '{32'h0, 32'h44, 32'h80, 32'h40, 32'h0, 32'h0};
    int n_errors = 0;
    int checks_done = 0;
    int seed = 10;
    int nIn = 0;
    int nOut = 0;
    int con = 68;
    int bri = 128;
    int sat = 64;

    always #50 clock = ~clock;

    component_video_path dut (.clock(clock), .reset(reset),
        .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .inRed(inRed),
        .inGreen(inGreen), .inBlue(inBlue), .inValid(inValid),
        .inReady(inReady), .outValid(outValid), .outReady(outReady),
        .outLuma(outLuma), .outChroma(outChroma), .outCrPhase(outCrPhase));
    video_sink sink (.clock(clock), .reset(reset), .outReady(outReady),
        .holdOff(holdOff));

    // ==========================================
    // Expected levels
    function automatic logic [7:0] lim(int v);
        return (v < 1) ? 8'h01 : (v > 254) ? 8'hFE : 8'(v);
    endfunction
    function automatic logic [7:0] lumf(int y);
        return lim((con * (y - 128)) / 68 + bri);
    endfunction
    function automatic logic [7:0] chrf(int c);
        return lim((sat * (c - 128)) / 64 + 128);
    endfunction
    function automatic int clip9i(int v);
        return (v < 0) ? 0 : (v > 511) ? 511 : v;
    endfunction
    // Matrix on the fixed-point weights; bypass passes Cr/Y/Cb through
    function automatic logic [23:0] exp3(int r, int g, int b);
        int y, cb, cr;
        y = g;
        cb = b;
        cr = r;
        if (!byp) begin
            y = (int'(K_YR) * r + int'(K_YG) * g + int'(K_YB) * b)
                >>> MAT_SHIFT;
            cb = clip9i(((int'(K_CB) * (b - y)) >>> MAT_SHIFT) + 256);
            cr = clip9i(((int'(K_CR) * (r - y)) >>> MAT_SHIFT) + 256);
        end
        return {lumf(y >> 1), chrf(cb >> 1), chrf(cr >> 1)};
    endfunction

    // ==========================================
    // Reporting
    task automatic wrap_up;
        $display("mismatches %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] x, logic [31:0] got);
        checks_done++;
        if (got !== x) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, x, got);
        end
    endtask
    task automatic timeout;
        n_errors++;
        $display("MISMATCH wait bound expected handshake seen none");
        wrap_up();
    endtask

    // ==========================================
    // Avalon-MM master
    task automatic bus(logic wr, logic [4:0] a, logic [31:0] d,
        logic [3:0] be);
        int t;
        @(posedge clock);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= wr;
        read <= !wr;
        for (t = 0; t < 50; t++) begin
            @(posedge clock);
            if (waitrequest === 1'b0) break;
        end
        if (t == 50) timeout();
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic setregs(int c, int b, int s, logic [1:0] ctl);
        con = c;
        bri = b;
        sat = s;
        byp = ctl[CTRL_BYPASS_BIT];
        bus(1'b1, ADDR_CONTRAST, 32'(c), 4'hF);
        bus(1'b1, ADDR_BRIGHTNESS, 32'(b), 4'hF);
        bus(1'b1, ADDR_SATURATION, 32'(s), 4'hF);
        bus(1'b1, ADDR_CONTROL, {30'h0, ctl}, 4'hF);
        bus(1'b0, ADDR_CONTROL, 32'h0, 4'hF);
        check("control", {30'h0, ctl}, q);
    endtask

    // ==========================================
    // Stream source: n equal samples, only settled words have luma and chroma compared
    task automatic block(logic [8:0] v1, logic [8:0] v2, logic [8:0] v3,
        int n);
        int k, t;
        logic [7:0] l, cb, cr;
        {l, cb, cr} = exp3(v1, v2, v3);
        @(posedge clock);
        inRed <= v1;
        inGreen <= v2;
        inBlue <= v3;
        inValid <= 1'b1;
        k = 0;
        for (t = 0; t < 3000 && k < n; t++) begin
            @(posedge clock);
            if (inReady === 1'b1) begin
                expQ.push_back({k >= 8 && k < n - 6, l, cb, cr});
                k++;
                nIn++;
            end
        end
        inValid <= 1'b0;
        if (k < n) timeout();
    endtask
    task automatic drain;
        int t;
        for (t = 0; t < 3000 && nOut < nIn - 6; t++) @(posedge clock);
        if (nOut < nIn - 6) timeout();
    endtask

    // ==========================================
    // Output monitor
    always @(posedge clock) begin
        if (outValid === 1'b1 && outReady === 1'b1) begin
            check("words pending", 32'h1, 32'(expQ.size() > 0));
            e = (expQ.size() > 0) ? expQ.pop_front() : 25'h0;
            check("phase", 32'(nOut % 2), 32'(outCrPhase));
            if (e[24]) begin
                check("luma", 32'(e[23:16]), 32'(outLuma));
                check("chroma", 32'(nOut % 2 ? e[7:0] : e[15:8]),
                    32'(outChroma));
            end
            nOut++;
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, addrs[i], 32'h0, 4'hF);
            check("reset value", rstv[i], q);
        end
        bus(1'b1, ADDR_CONTRAST, 32'h11, 4'h0);
        bus(1'b1, 5'h14, 32'h55, 4'hF);
        bus(1'b0, ADDR_CONTRAST, 32'h0, 4'hF);
        check("masked write", 32'h44, q);
        bus(1'b0, 5'h14, 32'h0, 4'hF);
        check("unmapped read", 32'h0, q);
        setregs(68, 128, 64, 2'b10);
        block(9'h000, 9'h000, 9'h000, 24);
        block(9'h1FF, 9'h1FF, 9'h1FF, 24);
        block(9'h0F0, 9'h100, 9'h020, 24);
        setregs(255, 0, 255, 2'b11);
        block(9'h1FF, 9'h000, 9'h001, 24);
        block(9'h000, 9'h100, 9'h000, 1);
        block(9'h1FF, 9'h000, 9'h001, 8);
        setregs(68, 128, 64, 2'b00);
        block(9'h1FF, 9'h000, 9'h1FF, 24);
        for (int i = 0; i < 4; i++) begin
            block(9'h0, 9'($random(seed)), 9'h0, 24);
        end
        for (int i = 0; i < 8; i++) begin
            setregs($random(seed) & 255, $random(seed) & 255,
                $random(seed) & 255, 2'($random(seed)));
            block(9'($random(seed)), 9'($random(seed)),
                9'($random(seed)), 24);
        end
        drain();
        holdOff <= 1'b1;
        block(9'h080, 9'h100, 9'h180, 16);
        repeat (2) @(posedge clock);
        check("full refuses", 32'h0, 32'(inReady));
        bus(1'b0, ADDR_STATUS, 32'h0, 4'hF);
        check("status full", 32'h30, q);
        holdOff <= 1'b0;
        drain();
        bus(1'b0, ADDR_STATUS, 32'h0, 4'hF);
        check("status empty", 32'h0, q);
        wrap_up();
    end
endmodule
